// file: rtl/lin_rx_filter_regs.vh
// register offsets, field positions and reset values of the lin receive
// store and identifier filter; included by the filter module's design file only
`ifndef LIN_RX_FILTER_REGS_VH
`define LIN_RX_FILTER_REGS_VH

// byte addresses on the register bus
`define ADDR_RX_BYTES_LOW   6'h00
`define ADDR_RX_BYTES_HIGH  6'h04
`define ADDR_ID_MASKS       6'h08
`define ADDR_SLAVE_ID       6'h0c
`define ADDR_CONTROL        6'h10
`define ADDR_STATUS         6'h14
`define ADDR_IRQ_MASK       6'h18

// mask word fields
`define RX_MASK_HI          23
`define RX_MASK_LO          16
`define TX_MASK_HI          7
`define TX_MASK_LO          0
// identification word field
`define SLAVE_ID_HI         15
`define SLAVE_ID_LO         8
// control bits
`define CTL_LIN_MODE        0
// status / interrupt mask bits
`define ST_RX_READY         0
`define ST_RECEIVE_IDENTIFIER_MATCH_FLAG            1
`define ST_TRANSMIT_IDENTIFIER_MATCH_FLAG            2
`define ST_WIDTH            3

`define MASK_RESET          8'h00
`define SLAVE_ID_RESET      8'h00
`define BYTE_RESET          8'h00
`define WORD_ZERO           32'h00000000
`define NUM_BYTES           8
`define LAST_INDEX          3'h7
`define COUNT_RESET         3'h0
`define FLAGS_RESET         3'h0

// write strobe lanes
`define LANE_RX_MASK        2
`define LANE_SLAVE_ID       1
`define LANE_LOW            0

`define RESP_OKAY           2'b00
`define RESP_SLVERR         2'b10

`endif

// file: rtl/id_match.v
// masked identifier compare for one mask
// assumes a purely combinational use inside the filter block
module id_match (
    input  wire [7:0] incoming_id,
    input  wire [7:0] slave_task_identifier,
    input  wire [7:0] id_mask,
    output wire       hit
);
    assign hit = ~|((incoming_id ^ slave_task_identifier) & ~id_mask);
endmodule

// file: rtl/lin_response_rx_buffer_id_mask.v
// lin receive byte store and identifier filter with axi4-lite registers
// assumes the receive shift register presents each data byte with a
// one-cycle strobe and each received identifier with its own strobe
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`include "lin_rx_filter_regs.vh"

// Functional notes
// - received byte goes to current count index
// - eight bytes packed in two words
// - reading byte 0 clears receive ready
// - frame byte x lands in buffer x-1
// - filter only in lin mode, two masks
// - receive mask hit sets flag, interrupt
// - transmit mask hit sets flag, interrupt
// - zero mask bits are compared
// - one mask bits are ignored
// - reserved mask bits read zero
// - compare against slave task identifier
module lin_response_rx_buffer_id_mask (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [5:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [5:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  receive_shift_register,
    input  wire        rx_byte_valid,
    input  wire        frame_start,
    input  wire [7:0]  incoming_id,
    input  wire        id_valid,
    output reg         irq,
    output reg         receive_ready_flag
);

    // ************************************************************
    // storage
    // ************************************************************
    reg [7:0]  rx_buf_q [0:7];
    reg [2:0]  byte_count_q;
    reg [7:0]  receive_identifier_mask_q;
    reg [7:0]  transmit_identifier_mask_q;
    reg [7:0]  slave_task_identifier_q;
    reg        lin_mode_q;
    reg [2:0]  status_q;
    reg [2:0]  irq_mask_q;
    reg [5:0]  aw_addr_q;
    reg        aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0]  w_strb_q;
    reg        w_have_q;
    wire       rx_hit;
    wire       tx_hit;
    wire       do_write;
    wire       do_read;
    wire       read_status;
    wire       read_low;
    reg [2:0]  events;
    reg [31:0] rd_word;
    reg        rd_ok;
    reg        wr_ok;
    integer    i;

    // merge a write with byte enables
    function [7:0] lane;
        input [7:0] old;
        input [7:0] new_byte;
        input       en;
        begin
            lane = en ? new_byte : old;
        end
    endfunction

    // ************************************************************
    // identifier filter
    // ************************************************************
    // slave task identifier reference
    id_match u_rx_match (
        .incoming_id           (incoming_id),
        .slave_task_identifier (slave_task_identifier_q),
        .id_mask               (receive_identifier_mask_q),
        .hit                   (rx_hit)
    );
    id_match u_tx_match (
        .incoming_id           (incoming_id),
        .slave_task_identifier (slave_task_identifier_q),
        .id_mask               (transmit_identifier_mask_q),
        .hit                   (tx_hit)
    );

    always @* begin
        events = 3'h0;
        events[`ST_RECEIVE_IDENTIFIER_MATCH_FLAG] = id_valid & lin_mode_q & rx_hit;
        events[`ST_TRANSMIT_IDENTIFIER_MATCH_FLAG] = id_valid & lin_mode_q & tx_hit;
        events[`ST_RX_READY] = rx_byte_valid & ~frame_start &
                               (byte_count_q == `LAST_INDEX);
    end

    // ************************************************************
    // bus handshake
    // ************************************************************
    assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;
    assign do_read  = s_axi_arvalid & s_axi_arready;
    assign read_status = do_read & (s_axi_araddr == `ADDR_STATUS);
    assign read_low    = do_read & (s_axi_araddr == `ADDR_RX_BYTES_LOW);

    always @* begin
        rd_ok = 1'b1;
        rd_word = `WORD_ZERO;
        case (s_axi_araddr)
            `ADDR_RX_BYTES_LOW:
                rd_word = {rx_buf_q[0], rx_buf_q[1], rx_buf_q[2], rx_buf_q[3]};
            `ADDR_RX_BYTES_HIGH:
                rd_word = {rx_buf_q[4], rx_buf_q[5], rx_buf_q[6], rx_buf_q[7]};
            `ADDR_ID_MASKS:
                rd_word = {8'h00, receive_identifier_mask_q,
                           8'h00, transmit_identifier_mask_q};
            `ADDR_SLAVE_ID:
                rd_word = {16'h0000, slave_task_identifier_q, 8'h00};
            `ADDR_CONTROL:
                rd_word = {31'h00000000, lin_mode_q};
            `ADDR_STATUS:
                rd_word = {29'h00000000, status_q | events};
            `ADDR_IRQ_MASK:
                rd_word = {29'h00000000, irq_mask_q};
            default:
                rd_ok = 1'b0;
        endcase
    end

    always @* begin
        case (aw_addr_q)
            `ADDR_ID_MASKS,
            `ADDR_SLAVE_ID,
            `ADDR_CONTROL,
            `ADDR_IRQ_MASK: wr_ok = 1'b1;
            default: wr_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= `RESP_OKAY;
            s_axi_rdata   <= `WORD_ZERO;
            aw_have_q     <= 1'b0;
            w_have_q      <= 1'b0;
            aw_addr_q     <= 6'h00;
            w_data_q      <= `WORD_ZERO;
            w_strb_q      <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready  <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
            s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
            if (s_axi_awvalid & s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid & s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_read) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            receive_identifier_mask_q  <= `MASK_RESET;
            transmit_identifier_mask_q <= `MASK_RESET;
            slave_task_identifier_q    <= `SLAVE_ID_RESET;
            lin_mode_q                 <= 1'b0;
            irq_mask_q                 <= `FLAGS_RESET;
        end else if (do_write) begin
            case (aw_addr_q)
                `ADDR_ID_MASKS: begin
                    receive_identifier_mask_q <= lane(
                        receive_identifier_mask_q,
                        w_data_q[`RX_MASK_HI:`RX_MASK_LO],
                        w_strb_q[`LANE_RX_MASK]);
                    transmit_identifier_mask_q <= lane(
                        transmit_identifier_mask_q,
                        w_data_q[`TX_MASK_HI:`TX_MASK_LO],
                        w_strb_q[`LANE_LOW]);
                end
                `ADDR_SLAVE_ID:
                    slave_task_identifier_q <= lane(slave_task_identifier_q,
                        w_data_q[`SLAVE_ID_HI:`SLAVE_ID_LO],
                        w_strb_q[`LANE_SLAVE_ID]);
                `ADDR_CONTROL:
                    if (w_strb_q[`LANE_LOW]) begin
                        lin_mode_q <= w_data_q[`CTL_LIN_MODE];
                    end
                `ADDR_IRQ_MASK:
                    if (w_strb_q[`LANE_LOW]) begin
                        irq_mask_q <= w_data_q[`ST_WIDTH-1:0];
                    end
                default: begin
                end
            endcase
        end
    end

    // ************************************************************
    // receive byte store
    // ************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            for (i = 0; i < `NUM_BYTES; i = i + 1) begin
                rx_buf_q[i] <= `BYTE_RESET;
            end
            byte_count_q <= `COUNT_RESET;
        end else if (frame_start) begin
            byte_count_q <= `COUNT_RESET;
        end else if (rx_byte_valid) begin
            rx_buf_q[byte_count_q] <= receive_shift_register;
            byte_count_q <= byte_count_q + 3'h1;
        end
    end

    // ************************************************************
    // status and interrupt
    // ************************************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            status_q           <= `FLAGS_RESET;
            receive_ready_flag <= 1'b0;
            irq                <= 1'b0;
        end else begin
            // set wins over read clear
            if (read_status) begin
                status_q <= events;
            end else begin
                status_q <= status_q | events;
            end
            if (events[`ST_RX_READY]) begin
                receive_ready_flag <= 1'b1;
            end else if (read_low) begin
                receive_ready_flag <= 1'b0;
            end
            irq <= |((read_status ? events : (status_q | events))
                     & irq_mask_q);
        end
    end

endmodule

// file: testbench/lin_rx_filter_asserts.sv
// checker for the lin receive store and identifier filter
// sees only the top module ports, bound below
module lin_rx_filter_asserts (
    input wire        aclk,
    input wire        aresetn,
    input wire [5:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [5:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        rx_byte_valid,
    input wire        receive_ready_flag
);
    // ****
    // helper logic
    // ****
    reg [5:0] ra_q;
    reg [5:0] wa_q;
    always @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
        if (s_axi_awvalid && s_axi_awready) wa_q <= s_axi_awaddr;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence ar_hs;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // ****
    // assertions
    // ****
    AST_AW_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    AST_R_ANSWER: assert property (ar_hs |=> s_axi_rvalid)
        else $error("read answer late");
    AST_READY_CLEAR: assert property (
        ar_hs ##0 (s_axi_araddr == 6'h00 && !rx_byte_valid)
        |-> ##[1:4] !receive_ready_flag)
        else $error("ready flag not cleared by byte 0 read");
    AST_READY_CAUSE: assert property (
        $rose(receive_ready_flag) |-> $past(rx_byte_valid))
        else $error("ready flag rose without a byte");
    AST_MASK_RSVD: assert property (
        s_axi_rvalid && ra_q == 6'h08
        |-> s_axi_rdata[31:24] == 8'h00 && s_axi_rdata[15:8] == 8'h00)
        else $error("reserved mask bits not zero");
    AST_RO_WRITE: assert property (
        s_axi_bvalid && wa_q < 6'h08 |-> s_axi_bresp == 2'b10)
        else $error("buffer write not refused");
endmodule

bind lin_response_rx_buffer_id_mask lin_rx_filter_asserts
    lin_rx_filter_asserts_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .rx_byte_valid,
    .receive_ready_flag);

// file: testbench/lin_node_model.sv
// lin bus node model: delivers identifiers and response bytes
// assumes tasks are called from the aclk domain
module lin_node_model (
    input  wire        aclk,
    output logic [7:0] receive_shift_register,
    output logic       rx_byte_valid,
    output logic       frame_start,
    output logic [7:0] incoming_id,
    output logic       id_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        receive_shift_register = 8'h00;
        rx_byte_valid = 1'b0;
        frame_start = 1'b0;
        incoming_id = 8'h00;
        id_valid = 1'b0;
    end
    task send_bytes(input logic [63:0] b);
        @(posedge aclk) frame_start <= 1'b1;
        @(posedge aclk) frame_start <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rx_byte_valid <= 1'b1;
            receive_shift_register <= b[63-8*i -: 8];
            @(posedge aclk);
        end
        rx_byte_valid <= 1'b0;
        receive_shift_register <= ~b[7:0];
    endtask
    task send_id(input logic [7:0] id);
        @(posedge aclk);
        incoming_id <= id;
        id_valid <= 1'b1;
        @(posedge aclk);
        id_valid <= 1'b0;
        incoming_id <= ~id;
    endtask
endmodule

// file: testbench/lin_response_rx_buffer_id_mask_tb.sv
// testbench of the lin receive store and identifier filter
// assumes the node model and the bound checker
module lin_response_rx_buffer_id_mask_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [3:0] wstrb = 4'hf;
    logic [1:0] bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, irq, rdy;
    logic [7:0] rsr, iid;
    logic rbv, fst, idv;
    logic [31:0] tbl [5] = '{32'h0000005a, 32'h1300005a, 32'h1101005b,
                             32'h120080da, 32'h1000005b};
    int n_errors = 0, n_checks = 0;
    always #12.5 aclk = ~aclk;
    lin_response_rx_buffer_id_mask lin_response_rx_buffer_id_mask_inst (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .receive_shift_register(rsr),
        .rx_byte_valid(rbv), .frame_start(fst), .incoming_id(iid),
        .id_valid(idv), .irq(irq), .receive_ready_flag(rdy));
    lin_node_model lin_node_model_inst (.aclk(aclk),
        .receive_shift_register(rsr), .rx_byte_valid(rbv),
        .frame_start(fst), .incoming_id(iid), .id_valid(idv));
    // ****
    // bus and compare tasks
    // ****
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time,
                     got, exp);
        end
    endtask
    task wr(input logic [5:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask
    task rd(input logic [5:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task rc(input logic [5:0] a, input logic [31:0] e);
        rd(a);
        chk(d, e);
    endtask
    // ****
    // scenarios
    // ****
    task t_reset;
        rc(6'h00, 32'h0);
        rc(6'h04, 32'h0);
        rc(6'h08, 32'h0);
    endtask
    task t_bytes;
        lin_node_model_inst.send_bytes(64'h1122334455667788);
        @(posedge aclk);
        chk({31'h0, rdy}, 32'h1);
        rc(6'h14, 32'h1);
        rc(6'h04, 32'h55667788);
        rc(6'h00, 32'h11223344);
        @(posedge aclk);
        chk({31'h0, rdy}, 32'h0);
    endtask
    task t_refuse;
        wr(6'h00, 32'hdeadbeef);
        chk({30'h0, r}, 32'h2);
        rc(6'h00, 32'h11223344);
        rc(6'h3c, 32'h0);
        chk({30'h0, r}, 32'h2);
        wr(6'h08, 32'hffffffff);
        rc(6'h08, 32'h00ff00ff);
        wstrb <= 4'h1;
        wr(6'h08, 32'h00000000);
        wstrb <= 4'hf;
        rc(6'h08, 32'h00ff0000);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
    endtask
    task t_filter;
        wr(6'h0c, 32'h00005a00);
        wr(6'h18, 32'h00000006);
        foreach (tbl[i]) begin
            wr(6'h10, {31'h0, tbl[i][28]});
            wr(6'h08, {8'h0, tbl[i][23:16], 8'h0, tbl[i][15:8]});
            lin_node_model_inst.send_id(tbl[i][7:0]);
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, {31'h0, |tbl[i][25:24]});
            rd(6'h14);
            chk({30'h0, d[2:1]}, {30'h0, tbl[i][25:24]});
            repeat (2) @(posedge aclk);
            chk({31'h0, irq}, 32'h0);
        end
    endtask
    task summarize;
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        summarize();
    end
    initial begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_bytes();
        t_refuse();
        t_filter();
        summarize();
    end
endmodule
